// [sslm_pkg.sv]
// constants, checksum and helper functions for the step-loss monitor
// Operation
// - check acts only when a stepper is driven
// - encoder counts scaled to steps by turn figures
// - enabling captures step and encoder reference pair
// - each step, converted encoder vs steps, beyond threshold
// - revolution sensor edge latches current step count
// - each turn, step mismatch reaching threshold flags
// - flag 0x01 enables checking
// - flag 0x02 picks revolution sensor, else encoder
// - flag 0x04 makes mismatch raise alarm
// - flag 0x08 makes sensor active high
// - flag 0x10 corrects slippage, encoder mode only
// - threshold is unsigned byte of steps
// - read request 4 bytes, reply 18 bytes
// - write request 18 bytes, answer 4-byte code
package sslm_pkg;
	localparam logic [31:0] CODE_READ = 32'h70746367;
	localparam logic [31:0] CODE_WRITE = 32'h70746373;
	localparam int FLG_ENABLE = 0;
	localparam int FLG_REV_SEL = 1;
	localparam int FLG_ALARM = 2;
	localparam int FLG_REV_INV = 3;
	localparam int FLG_SLIP_FIX = 4;
	localparam logic [7:0] THRESH_RST = 8'h00;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [4:0] CODE_LAST = 5'h03;
	localparam logic [4:0] BODY_CRC_LO = 5'h0c;
	localparam logic [4:0] BODY_LAST = 5'h0d;
	localparam logic [4:0] REPLY_LEN = 5'h12;
	localparam logic [4:0] ACK_LEN = 5'h04;
	localparam logic [4:0] REPLY_THR = 5'h04;
	localparam logic [4:0] REPLY_FLAGS = 5'h05;
	localparam logic [4:0] REPLY_CRC_LO = 5'h10;
	localparam logic [4:0] REPLY_CRC_HI = 5'h11;
	localparam int RESERVED_LEN = 10;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [5:0] DIV_STEPS = 6'h30;

	// one byte of the reflected 16-bit frame checksum
	function automatic logic [15:0] crc_byte(input logic [15:0] c,
		input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	// checksum of the settings body: threshold, flags, reserved zeros
	function automatic logic [15:0] crc_body(input logic [7:0] thr,
		input logic [7:0] flg);
		logic [15:0] r;
		r = crc_byte(crc_byte(CRC_INIT, thr), flg);
		for (int i = 0; i < RESERVED_LEN; i++) begin
			r = crc_byte(r, 8'h00);
		end
		return r;
	endfunction

	// magnitude of a 33-bit signed value
	function automatic logic [32:0] abs33(input logic [32:0] v);
		return v[32] ? (33'h000000000 - v) : v;
	endfunction
endpackage

// [sslm_enc_scale.sv]
// scales an encoder count difference into motor steps by long division
`timescale 1ns/100ps
module sslm_enc_scale (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic start,
	input wire logic [31:0] enc_delta,
	input wire logic [15:0] steps_per_turn,
	input wire logic [15:0] encoder_counts_per_turn,
	output logic busy,
	output logic done,
	output logic [31:0] steps
);
	logic [47:0] num_q;
	logic [16:0] rem_q;
	logic [15:0] den_q;
	logic [5:0] cnt_q;
	logic neg_q, busy_q, done_q;
	logic [31:0] mag;
	logic [16:0] trial;
	logic fits;
	logic [31:0] quo;

	// magnitude and one restoring division step
	assign mag = enc_delta[31] ? (32'h00000000 - enc_delta) : enc_delta;
	assign trial = {rem_q[15:0], num_q[47]};
	assign fits = trial >= {1'b0, den_q};
	assign quo = num_q[31:0];
	assign busy = busy_q;
	assign done = done_q;
	assign steps = neg_q ? (32'h00000000 - quo) : quo;

	// delta * steps_per_turn / counts_per_turn, one bit a cycle
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			num_q <= 48'h000000000000;
			rem_q <= 17'h00000;
			den_q <= 16'h0000;
			cnt_q <= 6'h00;
			neg_q <= 1'b0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else if (start && !busy_q) begin
			num_q <= {16'h0000, mag} * {32'h00000000, steps_per_turn};
			den_q <= encoder_counts_per_turn;
			rem_q <= 17'h00000;
			neg_q <= enc_delta[31];
			cnt_q <= sslm_pkg::DIV_STEPS;
			busy_q <= 1'b1;
			done_q <= 1'b0;
		end else if (busy_q) begin
			rem_q <= fits ? (trial - {1'b0, den_q}) : trial;
			num_q <= {num_q[46:0], fits};
			cnt_q <= cnt_q - 6'h01;
			busy_q <= cnt_q != 6'h01;
			done_q <= cnt_q == 6'h01;
		end else begin
			done_q <= 1'b0;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	// done is loaded on the 48th shift and is seen one edge later
	AST_DIV_TIME: assert property (start && !busy |-> ##49 done)
		else $error("scaled encoder result not ready after 49 cycles");
endmodule

// [sslm_monitor.sv]
// step-loss monitor: settings frames on the host link and mismatch check
`timescale 1ns/100ps
module sslm_monitor (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic tx_ready,
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic crc_error,
	input wire logic motor_is_stepper,
	input wire logic step_pulse,
	input wire logic [31:0] step_pos,
	input wire logic [31:0] enc_pos,
	input wire logic rev_sensor,
	input wire logic [15:0] steps_per_turn,
	input wire logic [15:0] encoder_counts_per_turn,
	output logic [7:0] mismatch_threshold,
	output logic [7:0] check_flags,
	output logic step_loss,
	output logic alarm_req,
	output logic slip_fix_valid,
	output logic [31:0] slip_fix_pos
);
	typedef enum logic [2:0] {
		SSLM_CMD = 3'b001,
		SSLM_BODY = 3'b010,
		SSLM_REPLY = 3'b100
	} sslm_state_t;

	sslm_state_t state_q, state_d;
	logic [31:0] code_q, reply_code_q;
	logic [4:0] cnt_q, reply_len_q;
	logic [7:0] thr_q, flags_q, new_thr_q, new_flags_q, crc_lo_q;
	logic [15:0] crc_q, reply_crc_q;
	logic tx_valid_q, crc_error_q;
	logic [7:0] tx_data_q;

	// reply byte chosen by index, used on each handshake to load the next byte
	function automatic logic [7:0] reply_byte(input logic [4:0] idx,
		input logic [31:0] code, input logic [7:0] thr,
		input logic [7:0] flg, input logic [15:0] crc);
		logic [7:0] r;
		r = 8'h00;
		if (idx < sslm_pkg::REPLY_THR) begin
			r = code[8*idx[1:0] +: 8];
		end else if (idx == sslm_pkg::REPLY_THR) begin
			r = thr;
		end else if (idx == sslm_pkg::REPLY_FLAGS) begin
			r = flg;
		end else if (idx == sslm_pkg::REPLY_CRC_LO) begin
			r = crc[7:0];
		end else if (idx == sslm_pkg::REPLY_CRC_HI) begin
			r = crc[15:8];
		end
		return r;
	endfunction

	// frame decoding
	logic [31:0] code_full;
	logic code_done, is_read, is_write, body_last, body_ok, apply;
	logic tx_fire, reply_last;
	logic [15:0] set_crc;
	assign code_full = {rx_data, code_q[31:8]};
	assign code_done = state_q == SSLM_CMD && rx_valid && cnt_q == sslm_pkg::CODE_LAST;
	assign is_read = code_done && code_full == sslm_pkg::CODE_READ;
	assign is_write = code_done && code_full == sslm_pkg::CODE_WRITE;
	assign body_last = state_q == SSLM_BODY && rx_valid && cnt_q == sslm_pkg::BODY_LAST;
	assign body_ok = {rx_data, crc_lo_q} == crc_q;
	assign apply = body_last && body_ok;
	assign tx_fire = tx_valid_q && tx_ready;
	assign reply_last = tx_fire && cnt_q == reply_len_q - 5'h01;
	assign set_crc = sslm_pkg::crc_body(thr_q, flags_q);

	// frame sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			SSLM_CMD: begin
				if (is_read) begin
					state_d = SSLM_REPLY;
				end else if (is_write) begin
					state_d = SSLM_BODY;
				end
			end
			SSLM_BODY: begin
				if (apply) begin
					state_d = SSLM_REPLY;
				end else if (body_last) begin
					state_d = SSLM_CMD;
				end
			end
			SSLM_REPLY: begin
				if (reply_last) begin
					state_d = SSLM_CMD;
				end
			end
			default: state_d = SSLM_CMD;
		endcase
	end

	// receive, check and answer settings frames
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_q <= SSLM_CMD;
			code_q <= 32'h00000000;
			reply_code_q <= 32'h00000000;
			reply_len_q <= 5'h00;
			reply_crc_q <= 16'h0000;
			cnt_q <= 5'h00;
			crc_q <= sslm_pkg::CRC_INIT;
			crc_lo_q <= 8'h00;
			new_thr_q <= sslm_pkg::THRESH_RST;
			new_flags_q <= sslm_pkg::FLAGS_RST;
			tx_valid_q <= 1'b0;
			tx_data_q <= 8'h00;
			crc_error_q <= 1'b0;
		end else begin
			state_q <= state_d;
			crc_error_q <= body_last && !body_ok;
			if (state_q == SSLM_CMD && rx_valid) begin
				code_q <= code_full;
				cnt_q <= code_done ? 5'h00 : cnt_q + 5'h01;
				crc_q <= sslm_pkg::CRC_INIT;
				if (is_read) begin
					reply_code_q <= sslm_pkg::CODE_READ;
					reply_len_q <= sslm_pkg::REPLY_LEN;
					reply_crc_q <= set_crc;
					tx_valid_q <= 1'b1;
					tx_data_q <= sslm_pkg::CODE_READ[7:0];
				end
			end else if (state_q == SSLM_BODY && rx_valid) begin
				cnt_q <= body_last ? 5'h00 : cnt_q + 5'h01;
				if (cnt_q < sslm_pkg::BODY_CRC_LO) begin
					crc_q <= sslm_pkg::crc_byte(crc_q, rx_data);
				end
				if (cnt_q == 5'h00) begin
					new_thr_q <= rx_data;
				end
				if (cnt_q == 5'h01) begin
					new_flags_q <= rx_data;
				end
				if (cnt_q == sslm_pkg::BODY_CRC_LO) begin
					crc_lo_q <= rx_data;
				end
				if (apply) begin
					reply_code_q <= sslm_pkg::CODE_WRITE;
					reply_len_q <= sslm_pkg::ACK_LEN;
					tx_valid_q <= 1'b1;
					tx_data_q <= sslm_pkg::CODE_WRITE[7:0];
				end
			end else if (tx_fire) begin
				cnt_q <= reply_last ? 5'h00 : cnt_q + 5'h01;
				tx_valid_q <= !reply_last;
				tx_data_q <= reply_byte(cnt_q + 5'h01, reply_code_q,
					thr_q, flags_q, reply_crc_q);
			end
		end
	end

	// settings take effect when a whole write frame checks out
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			thr_q <= sslm_pkg::THRESH_RST;
			flags_q <= sslm_pkg::FLAGS_RST;
		end else if (apply) begin
			thr_q <= new_thr_q;
			flags_q <= new_flags_q;
		end
	end

	// check control decoding
	logic run, rev_mode, rev_active, run_prev_q, capture;
	logic rev_prev_q, rev_edge, rev_have_q;
	assign run = flags_q[sslm_pkg::FLG_ENABLE] && motor_is_stepper;
	assign rev_mode = flags_q[sslm_pkg::FLG_REV_SEL];
	assign rev_active = flags_q[sslm_pkg::FLG_REV_INV] ? rev_sensor : !rev_sensor;
	assign capture = run && !run_prev_q;
	assign rev_edge = rev_active && !rev_prev_q;

	logic [31:0] ref_step_q, ref_enc_q, step_delta_q, rev_latch_q;
	logic conv_start, conv_busy, conv_done;
	logic [31:0] conv_steps;
	assign conv_start = run && !rev_mode && step_pulse && !conv_busy && !capture;

	sslm_enc_scale u_scale (
		.core_clk(core_clk),
		.reset(reset),
		.start(conv_start),
		.enc_delta(enc_pos - ref_enc_q),
		.steps_per_turn(steps_per_turn),
		.encoder_counts_per_turn(encoder_counts_per_turn),
		.busy(conv_busy),
		.done(conv_done),
		.steps(conv_steps)
	);

	// mismatch measures in both modes
	logic [32:0] enc_err, rev_moved, rev_err;
	logic enc_loss, rev_loss;
	assign enc_err = sslm_pkg::abs33({step_delta_q[31], step_delta_q}
		- {conv_steps[31], conv_steps});
	assign enc_loss = run && !rev_mode && conv_done
		&& enc_err > {25'h0000000, thr_q};
	assign rev_moved = sslm_pkg::abs33({1'b0, step_pos} - {1'b0, rev_latch_q}
		- 33'h000000000);
	assign rev_err = sslm_pkg::abs33(rev_moved - {17'h00000, steps_per_turn});
	assign rev_loss = run && rev_mode && rev_edge && rev_have_q
		&& rev_err >= {25'h0000000, thr_q};

	// reference capture, per-step snapshot and turn latch
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			run_prev_q <= 1'b0;
			rev_prev_q <= 1'b0;
			rev_have_q <= 1'b0;
			ref_step_q <= 32'h00000000;
			ref_enc_q <= 32'h00000000;
			step_delta_q <= 32'h00000000;
			rev_latch_q <= 32'h00000000;
		end else begin
			run_prev_q <= run;
			rev_prev_q <= rev_active;
			if (capture) begin
				ref_step_q <= step_pos;
				ref_enc_q <= enc_pos;
			end
			if (conv_start) begin
				step_delta_q <= step_pos - ref_step_q;
			end
			if (!run || !rev_mode) begin
				rev_have_q <= 1'b0;
			end else if (rev_edge) begin
				rev_latch_q <= step_pos;
				rev_have_q <= 1'b1;
			end
		end
	end

	// sticky loss flag, alarm and slippage correction
	logic step_loss_q, alarm_q, fix_valid_q;
	logic [31:0] fix_pos_q;
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			step_loss_q <= 1'b0;
			alarm_q <= 1'b0;
			fix_valid_q <= 1'b0;
			fix_pos_q <= 32'h00000000;
		end else begin
			fix_valid_q <= 1'b0;
			if (capture) begin
				step_loss_q <= 1'b0;
				alarm_q <= 1'b0;
			end else if (enc_loss || rev_loss) begin
				step_loss_q <= 1'b1;
				alarm_q <= alarm_q || flags_q[sslm_pkg::FLG_ALARM];
			end
			if (enc_loss && flags_q[sslm_pkg::FLG_SLIP_FIX]) begin
				fix_valid_q <= 1'b1;
				fix_pos_q <= ref_step_q + conv_steps;
			end
		end
	end

	assign tx_valid = tx_valid_q;
	assign tx_data = tx_data_q;
	assign crc_error = crc_error_q;
	assign mismatch_threshold = thr_q;
	assign check_flags = flags_q;
	assign step_loss = step_loss_q;
	assign alarm_req = alarm_q;
	assign slip_fix_valid = fix_valid_q;
	assign slip_fix_pos = fix_pos_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence s_read_code;
		state_q == SSLM_CMD && rx_valid && cnt_q == 5'h03
			&& code_full == 32'h70746367;
	endsequence
	sequence s_read_reply;
		tx_valid && tx_data == 8'h67 && state_q == SSLM_REPLY;
	endsequence

	AST_READ_REPLY: assert property (s_read_code |=> s_read_reply)
		else $error("read request not answered with its code");
	AST_WRITE_APPLY: assert property (apply |=> mismatch_threshold ==
		$past(new_thr_q) && tx_valid && tx_data == 8'h73)
		else $error("write frame not applied and acknowledged");
	AST_STEPPER_ONLY: assert property (!motor_is_stepper |-> !conv_start
		&& !rev_loss)
		else $error("check active without a stepper motor");
	AST_CAPTURE: assert property ($rose(run) |=> ref_step_q ==
		$past(step_pos) && ref_enc_q == $past(enc_pos))
		else $error("reference pair not captured on enable");
	AST_ENC_LOSS: assert property (enc_loss && !capture |=> step_loss)
		else $error("encoder mismatch did not set the loss flag");
	AST_REV_LATCH: assert property (run && rev_mode && rev_edge |=>
		rev_latch_q == $past(step_pos))
		else $error("step count not latched on sensor edge");
	AST_REV_LOSS: assert property (rev_loss && !capture |=> step_loss)
		else $error("turn mismatch did not set the loss flag");
	AST_ENABLE_GATE: assert property ($rose(step_loss) |->
		$past(check_flags[0]))
		else $error("loss flag set while checking disabled");
	AST_ALARM_CAUSE: assert property ($rose(alarm_req) |->
		$past(check_flags[2]) && step_loss)
		else $error("alarm raised without alarm flag");
	AST_FLAG_HOLD: assert property (step_loss && !capture |=> step_loss)
		else $error("loss flag dropped without recapture");
endmodule

// [sslm_host.sv]
// host-link model: sends request frames and collects reply bytes
`timescale 1ns/100ps
module sslm_host (
	input wire logic core_clk,
	output logic rx_valid,
	output logic [7:0] rx_data,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	input wire logic slow
);
	logic [7:0] got_q[$];
	logic stall_q = 1'b0;
	// link idle at time zero
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
	end
	// one byte per cycle, whole frame, little-endian fields
	task automatic send(input logic [7:0] b[$]);
		foreach (b[i]) begin
			@(posedge core_clk);
			rx_valid <= 1'b1;
			rx_data <= b[i];
		end
		@(posedge core_clk);
		rx_valid <= 1'b0;
		rx_data <= ~b[b.size()-1]; // released line shows no stale byte
	endtask
	// reply bytes taken only where ready meets valid; slow halves the rate
	always @(posedge core_clk) begin
		stall_q <= ~stall_q;
		tx_ready <= ~slow | stall_q;
		if (tx_valid && tx_ready)
			got_q.push_back(tx_data);
	end
endmodule

// [sslm_monitor_bench.sv]
// self-checking bench for the step-loss monitor
`timescale 1ns/100ps
module sslm_monitor_bench;
	typedef logic [7:0] sslm_bytes_t[$];
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic rx_valid, tx_ready, tx_valid, crc_error, slow = 1'b0;
	logic [7:0] rx_data, tx_data, mismatch_threshold, check_flags;
	logic motor_is_stepper = 1'b1, step_pulse = 1'b0, rev_sensor = 1'b1;
	logic [31:0] step_pos = 32'h0, enc_pos = 32'h0, slip_fix_pos;
	logic [15:0] steps_per_turn = 16'h00c8;
	logic [15:0] encoder_counts_per_turn = 16'h0190;
	logic step_loss, alarm_req, slip_fix_valid, crc_seen = 1'b0;
	logic [31:0] fix_seen = 32'h0;
	int fails = 0;
	int n_checks = 0;

	sslm_monitor u_dut (.core_clk, .reset, .rx_valid, .rx_data,
		.tx_ready, .tx_valid, .tx_data, .crc_error, .motor_is_stepper,
		.step_pulse, .step_pos, .enc_pos, .rev_sensor, .steps_per_turn,
		.encoder_counts_per_turn, .mismatch_threshold, .check_flags,
		.step_loss, .alarm_req, .slip_fix_valid, .slip_fix_pos);
	sslm_host u_host (.core_clk, .rx_valid, .rx_data, .tx_valid,
		.tx_data, .tx_ready, .slow);

	always #20 core_clk = ~core_clk;

	// remember one-cycle pulses for later checks
	always @(posedge core_clk) begin
		if (crc_error)
			crc_seen <= 1'b1;
		if (slip_fix_valid)
			fix_seen <= slip_fix_pos;
	end

	task automatic chk(input string s, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", s, e, g);
			fails++;
		end
	endtask

	// reflected checksum over threshold, flags and ten zero bytes
	function automatic logic [15:0] crc(input logic [7:0] t, f);
		logic [15:0] r;
		r = 16'hffff;
		for (int k = 0; k < 12; k++) begin
			r = r ^ {8'h00, ((k == 0) ? t : ((k == 1) ? f : 8'h00))};
			for (int i = 0; i < 8; i++)
				r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
		end
		return r;
	endfunction

	// 18-byte settings frame; both codes differ only in the first byte
	function automatic sslm_bytes_t frame(input logic [7:0] b0, t, f,
		input logic bad);
		sslm_bytes_t q;
		logic [15:0] c;
		c = crc(t, f) ^ {15'h0000, bad};
		q = {b0, 8'h63, 8'h74, 8'h70, t, f};
		repeat (10) q.push_back(8'h00);
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		return q;
	endfunction

	// wait for a whole reply, then for the link to go idle
	task automatic reply(input int n);
		int c;
		c = 0;
		while ((u_host.got_q.size() < n || tx_valid !== 1'b0) && c < 300) begin
			@(posedge core_clk);
			c++;
		end
		repeat (4) @(posedge core_clk);
		chk("reply length", n, u_host.got_q.size());
	endtask

	task automatic wr(input logic [7:0] t, f, input logic bad);
		sslm_bytes_t q;
		q = frame(8'h73, t, f, bad);
		u_host.got_q.delete();
		u_host.send(q);
		reply(bad ? 0 : 4);
		for (int i = 0; i < 4 && !bad; i++)
			chk("write answer", q[i], u_host.got_q[i]);
		if (!bad)
			chk("flags out", f, check_flags);
	endtask

	task automatic rd(input logic [7:0] t, f);
		sslm_bytes_t q;
		q = frame(8'h67, t, f, 1'b0);
		u_host.got_q.delete();
		u_host.send(q[0:3]);
		reply(18);
		foreach (q[i])
			chk("read reply", q[i], u_host.got_q[i]);
		chk("threshold out", t, mismatch_threshold);
	endtask

	// one motor step at the given positions, checked after the scaler
	task automatic step(input logic [31:0] s, e, input logic exp);
		step_pos <= s;
		enc_pos <= e;
		@(posedge core_clk);
		step_pulse <= 1'b1;
		@(posedge core_clk);
		step_pulse <= 1'b0;
		repeat (55) @(posedge core_clk);
		chk("step loss", exp, step_loss);
	endtask

	// one active pulse of the revolution sensor at a step count
	task automatic turn(input logic [31:0] s, input logic act);
		step_pos <= s;
		@(posedge core_clk);
		rev_sensor <= act;
		repeat (2) @(posedge core_clk);
		rev_sensor <= ~act;
		repeat (3) @(posedge core_clk);
	endtask

	task automatic test_done;
		if (fails == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// main sequence: settings frames, encoder checks, sensor checks
	initial begin
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		rd(8'h00, 8'h00);
		step(32'h0064, 32'h0, 1'b0);
		step_pos <= 32'h03e8;
		enc_pos <= 32'h07d0;
		wr(8'h05, 8'h01, 1'b0);
		step(32'h03f3, 32'h07dc, 1'b0);
		motor_is_stepper <= 1'b0;
		step(32'h0500, 32'h07dc, 1'b0);
		motor_is_stepper <= 1'b1;
		repeat (2) @(posedge core_clk);
		step(32'h0506, 32'h07dc, 1'b1);
		chk("alarm off", 1'b0, alarm_req);
		wr(8'h05, 8'h01, 1'b1);
		chk("crc error", 1'b1, crc_seen);
		rd(8'h05, 8'h01);
		chk("loss held", 1'b1, step_loss);
		u_host.got_q.delete();
		u_host.send({8'h11, 8'h22, 8'h33, 8'h44});
		reply(0);
		wr(8'h05, 8'h00, 1'b0);
		chk("loss kept", 1'b1, step_loss);
		wr(8'h05, 8'h05, 1'b0);
		chk("loss cleared", 1'b0, step_loss);
		step(32'h050d, 32'h07de, 1'b1);
		chk("alarm on", 1'b1, alarm_req);
		wr(8'h05, 8'h00, 1'b0);
		wr(8'h05, 8'h11, 1'b0);
		chk("alarm cleared", 1'b0, alarm_req);
		step(32'h0521, 32'h07f2, 1'b1);
		chk("slip fix", 32'h0517, fix_seen);
		wr(8'h05, 8'h00, 1'b0);
		slow <= 1'b1;
		wr(8'h05, 8'h03, 1'b0);
		rd(8'h05, 8'h03);
		slow <= 1'b0;
		step(32'h1000, 32'h0, 1'b0);
		turn(32'h0064, 1'b0);
		turn(32'h012c, 1'b0);
		turn(32'h01f8, 1'b0);
		chk("turn within", 1'b0, step_loss);
		turn(32'h02c5, 1'b0);
		chk("turn short", 1'b1, step_loss);
		wr(8'h05, 8'h00, 1'b0);
		rev_sensor <= 1'b0;
		wr(8'h05, 8'h0b, 1'b0);
		turn(32'h0064, 1'b1);
		turn(32'h012c, 1'b1);
		turn(32'h01f0, 1'b1);
		chk("inverted within", 1'b0, step_loss);
		turn(32'h02b3, 1'b1);
		chk("inverted short", 1'b1, step_loss);
		test_done;
	end

	// cut a hang short well after the sequence should have ended
	initial begin
		#400000;
		fails++;
		test_done;
	end
endmodule
